// *** logic/lsi_pkg.sv ***
// Constants and types for the identity inquiry command handler
package lsi_pkg;
    localparam logic [10:0] LSI_REQ_ID     = 11'h7E5;
    localparam logic [10:0] LSI_RSP_ID     = 11'h7E4;
    localparam logic [7:0]  LSI_INQ_VENDOR = 8'h5A;
    localparam logic [7:0]  LSI_INQ_PROD   = 8'h5B;
    localparam logic [7:0]  LSI_INQ_REV    = 8'h5C;
    localparam logic [7:0]  LSI_INQ_SERIAL = 8'h5D;
    localparam logic [7:0]  LSI_INQ_NODE   = 8'h5E;
    localparam logic [7:0]  LSI_SEL_VENDOR = 8'h46;
    localparam logic [7:0]  LSI_SEL_PROD   = 8'h47;
    localparam logic [7:0]  LSI_SEL_REVLO  = 8'h48;
    localparam logic [7:0]  LSI_SEL_REVHI  = 8'h49;
    localparam logic [7:0]  LSI_SEL_SERLO  = 8'h4A;
    localparam logic [7:0]  LSI_SEL_SERHI  = 8'h4B;
    localparam logic [7:0]  LSI_ID_NONCFG  = 8'h4C;
    localparam logic [7:0]  LSI_RSP_MATCH  = 8'h4F;
    localparam logic [7:0]  LSI_RSP_NONCFG = 8'h50;
    localparam logic [7:0]  LSI_NODE_INVAL = 8'hFF;
    localparam logic [63:0] LSI_ZERO_FRAME = 64'h0;
    // Selection step index after each accepted selection frame
    localparam logic [2:0]  LSI_STEP_IDLE  = 3'h0;
    localparam logic [2:0]  LSI_STEP_DONE  = 3'h6;
    typedef enum logic [1:0] {LSI_CMP_EQ, LSI_CMP_GE, LSI_CMP_LE}
        lsi_cmp_t;
endpackage : lsi_pkg

// *** logic/lsi_field_cmp.sv ***
// Registered 32-bit comparator used by the selection match
`timescale 1ns/100ps
module lsi_field_cmp
    import lsi_pkg::*;
(
    input  wire logic          clock,
    input  wire logic          rst_b,
    input  wire logic          load,
    input  wire lsi_pkg::lsi_cmp_t mode,
    input  wire logic [31:0]   own,
    input  wire logic [31:0]   sel,
    output logic               hit_q
);
    // Result held until the next selection frame loads it
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            hit_q <= 1'b0;
        end else if (load) begin
            case (mode)
                LSI_CMP_EQ: hit_q <= (own == sel);
                LSI_CMP_GE: hit_q <= (own >= sel);
                LSI_CMP_LE: hit_q <= (own <= sel);
                default:    hit_q <= 1'b0;
            endcase
        end
    end
endmodule : lsi_field_cmp

// *** logic/lsi_identity_inquiry.sv ***
// Slave-side handler for identity inquiry and identification commands
`timescale 1ns/100ps
// Operation
// - Identity replies go out on 7E4h with the code and a 32-bit LSB-first value.
// - The node-ID reply holds 5Eh and the present node-ID in byte 2.
// - Inquiries are answered only in configuration state.
// - After a full selection a reply 4Fh is sent only if all fields match.
// - Selection frames are never acknowledged one by one.
// - Reply 50h to 4Ch only while the node-ID is FFh.
module lsi_identity_inquiry
    import lsi_pkg::*;
(
    input  wire logic        clock,
    input  wire logic        rst_b,
    input  wire logic        rxValid,
    input  wire logic [10:0] rxId,
    input  wire logic [63:0] rxData,
    input  wire logic        cfgState,
    input  wire logic [7:0]  nodeId,
    input  wire logic [31:0] vendorId,
    input  wire logic [31:0] productCode,
    input  wire logic [31:0] revisionNum,
    input  wire logic [31:0] serialNum,
    output logic             txValid_q,
    output logic [10:0]      txId_q,
    output logic [63:0]      txData_q
);
    logic [7:0]  cmd;
    logic [31:0] value;
    logic        isReq;
    logic [2:0]  selStep_q;
    logic [2:0]  selStep_d;
    logic        selLoad;
    logic [5:0]  hit;
    logic        evalDone_q;
    lsi_cmp_t    cmpMode [6];
    logic [31:0] cmpOwn  [6];

    // Byte 1 is the low byte of the frame; bytes 2..5 hold the value
    assign cmd   = rxData[7:0];
    assign value = rxData[39:8];
    assign isReq = rxValid && (rxId == LSI_REQ_ID);

    // Compare mode and own value per comparator, in selection frame order
    assign cmpMode[0] = LSI_CMP_EQ;
    assign cmpMode[1] = LSI_CMP_EQ;
    assign cmpMode[2] = LSI_CMP_GE;
    assign cmpMode[3] = LSI_CMP_LE;
    assign cmpMode[4] = LSI_CMP_GE;
    assign cmpMode[5] = LSI_CMP_LE;
    assign cmpOwn[0]  = vendorId;
    assign cmpOwn[1]  = productCode;
    assign cmpOwn[2]  = revisionNum;
    assign cmpOwn[3]  = revisionNum;
    assign cmpOwn[4]  = serialNum;
    assign cmpOwn[5]  = serialNum;

    // Selection sequencer; out-of-order frames abort the selection
    always_comb begin
        selStep_d = selStep_q;
        selLoad   = 1'b0;
        if (isReq && cmd == LSI_SEL_VENDOR) begin
            selStep_d = 3'h1;
            selLoad   = 1'b1;
        end else if (isReq && cmd > LSI_SEL_VENDOR
                     && cmd <= LSI_SEL_SERHI) begin
            if (selStep_q != LSI_STEP_IDLE && selStep_q != LSI_STEP_DONE
                && cmd == LSI_SEL_VENDOR + {5'h0, selStep_q}) begin
                selStep_d = selStep_q + 3'h1;
                selLoad   = 1'b1;
            end else begin
                selStep_d = LSI_STEP_IDLE;
            end
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_b) begin
            selStep_q <= LSI_STEP_IDLE;
        end else begin
            selStep_q <= selStep_d;
        end
    end

    // One comparator per selection field; only an accepted frame
    // carrying that field's own code loads it
    for (genvar i = 0; i < 6; i++) begin : gCmp
        lsi_field_cmp uCmp (
            .clock (clock),
            .rst_b (rst_b),
            .load  (selLoad && cmd == LSI_SEL_VENDOR + 8'(i)),
            .mode  (cmpMode[i]),
            .own   (cmpOwn[i]),
            .sel   (value),
            .hit_q (hit[i])
        );
    end

    // Pulse once the sixth frame's compare has landed
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            evalDone_q <= 1'b0;
        end else begin
            evalDone_q <= selLoad && selStep_d == LSI_STEP_DONE;
        end
    end

    // Reply builder; selection frames themselves get no reply
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            txValid_q <= 1'b0;
            txId_q    <= LSI_RSP_ID;
            txData_q  <= LSI_ZERO_FRAME;
        end else begin
            txValid_q <= 1'b0;
            if (evalDone_q && (&hit)) begin
                // Match reply wins; a failed match lets the request through
                txValid_q <= 1'b1;
                txId_q    <= LSI_RSP_ID;
                txData_q  <= {56'h0, LSI_RSP_MATCH};
            end else if (isReq) begin
                case (cmd)
                    LSI_INQ_VENDOR, LSI_INQ_PROD,
                    LSI_INQ_REV, LSI_INQ_SERIAL: begin
                        if (cfgState) begin
                            txValid_q <= 1'b1;
                            txId_q    <= LSI_RSP_ID;
                            txData_q  <= {24'h0,
                                (cmd == LSI_INQ_VENDOR) ? vendorId :
                                (cmd == LSI_INQ_PROD)   ? productCode :
                                (cmd == LSI_INQ_REV)    ? revisionNum :
                                                          serialNum,
                                cmd};
                        end
                    end
                    LSI_INQ_NODE: begin
                        if (cfgState) begin
                            txValid_q <= 1'b1;
                            txId_q    <= LSI_RSP_ID;
                            txData_q  <= {48'h0, nodeId, cmd};
                        end
                    end
                    LSI_ID_NONCFG: begin
                        if (nodeId == LSI_NODE_INVAL) begin
                            txValid_q <= 1'b1;
                            txId_q    <= LSI_RSP_ID;
                            txData_q  <= {56'h0, LSI_RSP_NONCFG};
                        end
                    end
                    default: ;
                endcase
            end
        end
    end

    // Checks
    // Six in-order frames just accepted; the verdict lands a cycle later
    sequence sSelDone;
        selLoad && selStep_d == LSI_STEP_DONE;
    endsequence
    // Verdict cycle with a field outside its selection and no request
    sequence sSelMiss;
        sSelDone ##1 (!(&hit) && !isReq);
    endsequence

    // Selection outcome: one reply on a full match, silence on a miss with no request
    chk_match_reply: assert property (
        @(posedge clock) disable iff (!rst_b)
        sSelDone ##1 (&hit) |=> txValid_q && txData_q[7:0] == LSI_RSP_MATCH)
        else $error("match reply missing");
    chk_match_silent: assert property (
        @(posedge clock) disable iff (!rst_b)
        sSelMiss |=> !txValid_q)
        else $error("reply sent without a full match");
    chk_eval_order: assert property (
        @(posedge clock) disable iff (!rst_b)
        evalDone_q |-> $past(isReq) && $past(cmd) == LSI_SEL_SERHI)
        else $error("match evaluated before the last frame");

    // Inquiries: refused outside configuration, exact vendor and node-ID frames inside
    chk_inq_cfg: assert property (
        @(posedge clock) disable iff (!rst_b)
        isReq && !cfgState && cmd >= LSI_INQ_VENDOR && cmd <= LSI_INQ_NODE
        && !evalDone_q |=> !txValid_q)
        else $error("inquiry answered outside config");
    chk_node_reply: assert property (
        @(posedge clock) disable iff (!rst_b)
        isReq && cfgState && cmd == LSI_INQ_NODE && !evalDone_q |=>
        txValid_q && txData_q == {48'h0, $past(nodeId), LSI_INQ_NODE})
        else $error("node reply wrong");
    chk_id_value: assert property (
        @(posedge clock) disable iff (!rst_b)
        isReq && cfgState && cmd == LSI_INQ_VENDOR && !evalDone_q |=>
        txData_q[39:8] == $past(vendorId) && txId_q == LSI_RSP_ID
        && txValid_q && txData_q[7:0] == LSI_INQ_VENDOR
        && txData_q[63:40] == 24'h0)
        else $error("identity reply wrong");
    chk_noncfg: assert property (
        @(posedge clock) disable iff (!rst_b)
        isReq && cmd == LSI_ID_NONCFG && !evalDone_q |=>
        txValid_q == ($past(nodeId) == LSI_NODE_INVAL)
        && (!txValid_q || txData_q == {56'h0, LSI_RSP_NONCFG}))
        else $error("non-configured reply wrong");

    // Selection frames, unknown codes and foreign frames draw no reply
    chk_sel_silent: assert property (
        @(posedge clock) disable iff (!rst_b)
        isReq && cmd >= LSI_SEL_VENDOR && cmd <= LSI_SEL_SERHI
        && !evalDone_q |=> !txValid_q)
        else $error("selection frame acknowledged");
    chk_unknown: assert property (
        @(posedge clock) disable iff (!rst_b)
        isReq && !evalDone_q
        && !(cmd inside {[LSI_SEL_VENDOR:LSI_ID_NONCFG],
                         [LSI_INQ_VENDOR:LSI_INQ_NODE]})
        |=> $stable(selStep_q) && !txValid_q)
        else $error("unknown code changed state");
    chk_other_id: assert property (
        @(posedge clock) disable iff (!rst_b)
        rxValid && rxId != LSI_REQ_ID && !evalDone_q
        |=> !txValid_q && $stable(selStep_q))
        else $error("frame on a foreign identifier acted on");
    chk_vendor_restart: assert property (
        @(posedge clock) disable iff (!rst_b)
        isReq && cmd == LSI_SEL_VENDOR |=> selStep_q == 3'h1)
        else $error("vendor frame did not restart");
    chk_reply_id: assert property (
        @(posedge clock) disable iff (!rst_b)
        txValid_q |-> txId_q == LSI_RSP_ID)
        else $error("reply on wrong identifier");
endmodule : lsi_identity_inquiry

// *** bench/lsi_master_model.sv ***
// Behavioural request master driving frames into the handler
`timescale 1ns/100ps
module lsi_master_model
    import lsi_pkg::*;
(
    input  wire logic        clock,
    output logic             rxValid,
    output logic [10:0]      rxId,
    output logic [63:0]      rxData
);
    // Quiet lines at time zero
    initial begin
        rxValid = 1'b0;
        rxId    = 11'h000;
        rxData  = 64'h0;
    end

    // One frame, one cycle; never waits for a confirmation
    task automatic send(input logic [10:0] id, input logic [7:0] code,
                        input logic [31:0] val);
        @(posedge clock);
        rxValid <= 1'b1;
        rxId    <= id;
        rxData  <= {24'h0, val, code};
        @(posedge clock);
        rxValid <= 1'b0;
        // Stale bytes inverted so nothing leans on held data
        rxData  <= ~{24'h0, val, code};
    endtask : send
endmodule : lsi_master_model

// *** bench/lsi_identity_inquiry_test.sv ***
// Self-checking bench for the identity inquiry handler
`timescale 1ns/100ps
module lsi_identity_inquiry_test;
    import lsi_pkg::*;
    logic        clock    = 1'b0;
    logic        rst_b    = 1'b0;
    logic        cfgState = 1'b1;
    logic [7:0]  nodeId   = 8'h12;
    logic [31:0] own [4]  = '{32'h1234_5678, 32'hCAFE_0001,
                              32'h0000_0010, 32'hA000_0000};
    logic [31:0] sv [6]   = '{32'h1234_5678, 32'hCAFE_0001, 32'h0000_0010,
                              32'h0000_0010, 32'hA000_0000, 32'hA000_0000};
    logic        rxValid;
    logic        txValid_q;
    logic [10:0] rxId;
    logic [10:0] txId_q;
    logic [63:0] rxData;
    logic [63:0] txData_q;
    int          mismatches = 0;
    int          n_checks   = 0;

    // 20 MHz clock
    always #25 clock = ~clock;

    lsi_master_model lsi_master_model_i (.clock(clock), .rxValid(rxValid),
        .rxId(rxId), .rxData(rxData));

    lsi_identity_inquiry lsi_identity_inquiry_i (.clock(clock),
        .rst_b(rst_b), .rxValid(rxValid), .rxId(rxId), .rxData(rxData),
        .cfgState(cfgState), .nodeId(nodeId), .vendorId(own[0]),
        .productCode(own[1]), .revisionNum(own[2]), .serialNum(own[3]),
        .txValid_q(txValid_q), .txId_q(txId_q), .txData_q(txData_q));

    task automatic check(input string what, input logic [63:0] seen,
                         input logic [63:0] exp);
        n_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic req(input logic [7:0] code, input logic [31:0] val);
        lsi_master_model_i.send(LSI_REQ_ID, code, val);
    endtask : req

    // Pulse expected (or not) just after the taking edge
    task automatic reply(input logic want, input logic [63:0] exp);
        #1;
        check("txValid_q", {63'h0, txValid_q}, {63'h0, want});
        if (want) begin
            check("txId_q", {53'h0, txId_q}, {53'h0, LSI_RSP_ID});
            check("txData_q", txData_q, exp);
        end
    endtask : reply

    // Six selection frames in the given code order
    task automatic sel(input logic [47:0] codes, input logic want);
        for (int i = 0; i < 6; i++) begin
            req(codes[8*i +: 8], sv[codes[8*i +: 8] - 8'h46]);
            reply(1'b0, 64'h0);
        end
        // Verdict comes one cycle after the last frame is taken
        @(posedge clock);
        reply(want, {56'h0, LSI_RSP_MATCH});
    endtask : sel

    task automatic t_inquire;
        for (int i = 0; i < 4; i++) begin
            req(LSI_INQ_VENDOR + i[7:0], 32'h0);
            reply(1'b1, {24'h0, own[i], LSI_INQ_VENDOR + i[7:0]});
        end
        // Pulse gone a cycle later, reply bytes still held
        @(posedge clock);
        reply(1'b0, 64'h0);
        check("txData_q", txData_q,
              {24'h0, own[3], LSI_INQ_SERIAL});
        req(LSI_INQ_NODE, 32'h0);
        reply(1'b1, {48'h0, nodeId, LSI_INQ_NODE});
    endtask : t_inquire

    task automatic t_refuse;
        @(posedge clock) cfgState <= 1'b0;
        req(LSI_INQ_VENDOR, 32'h0);
        reply(1'b0, 64'h0);
        req(LSI_INQ_NODE, 32'h0);
        reply(1'b0, 64'h0);
        @(posedge clock) cfgState <= 1'b1;
        req(LSI_ID_NONCFG, 32'h0);
        reply(1'b0, 64'h0);
        @(posedge clock) nodeId <= LSI_NODE_INVAL;
        req(LSI_ID_NONCFG, 32'h0);
        reply(1'b1, {56'h0, LSI_RSP_NONCFG});
        req(8'h13, 32'h0);
        reply(1'b0, 64'h0);
        lsi_master_model_i.send(LSI_RSP_ID, LSI_INQ_NODE, 32'h0);
        reply(1'b0, 64'h0);
    endtask : t_refuse

    // Spans set exactly at the own values, the tightest match
    task automatic t_select;
        sel(48'h4B4A49484746, 1'b1);
        sv[5] = 32'h9FFF_FFFF;
        sel(48'h4B4A49484746, 1'b0);
        sv[5] = 32'hA000_0000;
        sel(48'h4B4A49474846, 1'b0);
        req(LSI_SEL_VENDOR, sv[0]);
        req(LSI_SEL_PROD, sv[1]);
        sel(48'h4B4A49484746, 1'b1);
    endtask : t_select

    task automatic conclude;
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : conclude

    // Main sequence after a six-cycle reset
    initial begin
        repeat (6) @(posedge clock);
        rst_b <= 1'b1;
        #1;
        check("txData_q", txData_q, 64'h0);
        check("txValid_q", {63'h0, txValid_q}, 64'h0);
        check("txId_q", {53'h0, txId_q}, {53'h0, LSI_RSP_ID});
        t_inquire;
        t_refuse;
        t_select;
        conclude;
    end

    // Watchdog, far beyond the roughly 90 cycles the tests need
    initial begin
        repeat (2000) @(posedge clock);
        mismatches++;
        conclude;
    end
endmodule : lsi_identity_inquiry_test
